// ---- clp_cells.sv ----
// Two-input, set/reset and pipe-delay configurable logic cells with config registers.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Two-input table from four config bits.
// - Two-input sequential: input0 data, input1 clock.
// - Clock invert bit selects clock polarity.
// - Plain clock flip-flop loads on rise.
// - Inverted clock flip-flop loads on fall.
// - Plain clock latch transparent while clock low.
// - Inverted clock latch transparent while clock high.
// - Sequential outputs have selectable output polarity.
// - Initial state bit sets stored value.
// - Three-input table from eight config bits.
// - Set/reset cell: data, clock, clear-or-preset.
// - Clear low forces stored state zero.
// - Preset low forces stored state one.
// - Config bit picks clear or preset.
// - Pipe mode: input, clock, clear; two outputs.
// - Each tap picks 1-8 stages; second invertible.
// - Eight chained flip-flops, per-output tap mux.
// - Pipe clear low: reset, all outputs low.
// - Each input picked by 5-bit routing select.
module clp_cells
	import clp_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Routing lines
	input  wire logic [31:0] route_lines,
	// Cell outputs back to routing
	output logic             cell_a_out,
	output logic             cell_b_out,
	output logic             pipe_tap_first,
	output logic             pipe_tap_second
);

	// ----------------------------------------------------------------
	// Routed inputs
	// ----------------------------------------------------------------
	clp_state_s r;
	clp_state_s n;
	logic       a_in0, a_in1, b_in0, b_in1, b_in2, c_in0, c_in1, c_in2;
	logic [1:0] idx_a;
	logic [2:0] idx_b, idx_c;
	logic       q_a_nxt, q_b_nxt;
	logic [7:0] pipe_nxt;
	logic       pipe_rise;

	assign a_in0 = route_lines[r.cfg_a_ff[CLP_A_SEL0 +: CLP_SEL_W]];
	assign a_in1 = route_lines[r.cfg_a_ff[CLP_A_SEL1 +: CLP_SEL_W]];
	assign b_in0 = route_lines[r.cfg_b_ff[CLP_B_SEL0 +: CLP_SEL_W]];
	assign b_in1 = route_lines[r.cfg_b_ff[CLP_B_SEL1 +: CLP_SEL_W]];
	assign b_in2 = route_lines[r.cfg_b_ff[CLP_B_SEL2 +: CLP_SEL_W]];
	assign c_in0 = route_lines[r.cfg_c_ff[CLP_C_SEL0 +: CLP_SEL_W]];
	assign c_in1 = route_lines[r.cfg_c_ff[CLP_C_SEL1 +: CLP_SEL_W]];
	assign c_in2 = route_lines[r.cfg_c_ff[CLP_C_SEL2 +: CLP_SEL_W]];

	assign idx_a = {a_in1, a_in0};
	assign idx_b = {b_in2, b_in1, b_in0};
	assign idx_c = {c_in2, c_in1, c_in0};

	// ----------------------------------------------------------------
	// Flip-flop or latch step
	// ----------------------------------------------------------------
	// The routed clock is sampled; an edge is a change from the prior sample.
	function automatic logic clp_seq_step(
		input logic q,
		input logic d,
		input logic ck,
		input logic ck_prev,
		input logic latch,
		input logic inv
	);
		logic c;
		logic cp;
		c  = ck ^ inv;
		cp = ck_prev ^ inv;
		clp_seq_step = q;
		if (latch) begin
			if (!c) begin
				clp_seq_step = d;
			end
		end else if (c && !cp) begin
			clp_seq_step = d;
		end
	endfunction : clp_seq_step

	always_comb begin
		q_a_nxt = clp_seq_step(r.q_a_ff, a_in0, a_in1, r.clk_prev_ff[0],
			r.cfg_a_ff[CLP_A_LATCH], r.cfg_a_ff[CLP_A_CKINV]);
		q_b_nxt = clp_seq_step(r.q_b_ff, b_in0, b_in1, r.clk_prev_ff[1],
			r.cfg_b_ff[CLP_B_LATCH], r.cfg_b_ff[CLP_B_CKINV]);
		if (!b_in2) begin
			q_b_nxt = r.cfg_b_ff[CLP_B_PRESET];
		end
		pipe_rise = c_in1 && !r.clk_prev_ff[2];
		pipe_nxt  = r.pipe_ff;
		if (!c_in2) begin
			pipe_nxt = 8'h00;
		end else if (pipe_rise) begin
			pipe_nxt = {r.pipe_ff[6:0], c_in0};
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		n.clk_prev_ff = {c_in1, b_in1, a_in1};
		n.q_a_ff      = q_a_nxt;
		n.q_b_ff      = q_b_nxt;
		n.pipe_ff     = r.cfg_c_ff[CLP_C_PIPE] ? pipe_nxt : 8'h00;

		if (reg_wr) begin
			case (reg_addr)
				CLP_ADDR_CFG_A: begin
					n.cfg_a_ff = reg_wdata;
					n.q_a_ff   = reg_wdata[CLP_A_INIT];
				end
				CLP_ADDR_CFG_B: begin
					n.cfg_b_ff = reg_wdata;
					n.q_b_ff   = reg_wdata[CLP_B_INIT];
				end
				CLP_ADDR_CFG_C: begin
					n.cfg_c_ff = reg_wdata;
					n.pipe_ff  = 8'h00;
				end
				default: begin
				end
			endcase
		end

		if (n.cfg_a_ff[CLP_A_SEQ]) begin
			n.out_a_ff = n.q_a_ff ^ n.cfg_a_ff[CLP_A_QINV];
		end else begin
			n.out_a_ff = r.cfg_a_ff[CLP_A_LUT + 32'(idx_a)];
		end
		if (n.cfg_b_ff[CLP_B_SEQ]) begin
			n.out_b_ff = n.q_b_ff ^ n.cfg_b_ff[CLP_B_QINV];
		end else begin
			n.out_b_ff = r.cfg_b_ff[CLP_B_LUT + 32'(idx_b)];
		end
		if (!n.cfg_c_ff[CLP_C_PIPE]) begin
			n.tap0_ff = r.cfg_c_ff[CLP_C_LUT + 32'(idx_c)];
			n.tap1_ff = 1'b0;
		end else if (!c_in2) begin
			n.tap0_ff = 1'b0;
			n.tap1_ff = 1'b0;
		end else begin
			n.tap0_ff = n.pipe_ff[n.cfg_c_ff[CLP_C_TAP0 +: 3]];
			n.tap1_ff = n.pipe_ff[n.cfg_c_ff[CLP_C_TAP1 +: 3]]
				^ n.cfg_c_ff[CLP_C_QINV1];
		end

		n.rdata_ff = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				CLP_ADDR_CFG_A:  n.rdata_ff = r.cfg_a_ff;
				CLP_ADDR_CFG_B:  n.rdata_ff = r.cfg_b_ff;
				CLP_ADDR_CFG_C:  n.rdata_ff = r.cfg_c_ff;
				CLP_ADDR_STATUS: n.rdata_ff = {16'h0000, r.pipe_ff, 2'b00, r.q_b_ff,
					r.q_a_ff, r.tap1_ff, r.tap0_ff, r.out_b_ff, r.out_a_ff};
				default:         n.rdata_ff = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign reg_rdata       = r.rdata_ff;
	assign cell_a_out      = r.out_a_ff;
	assign cell_b_out      = r.out_b_ff;
	assign pipe_tap_first  = r.tap0_ff;
	assign pipe_tap_second = r.tap1_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// A write reloads the stored state, so the checks other than p_init and p_init_b skip cycles with the write strobe.
	logic seq_a, ff_a, seq_b;
	assign seq_a = r.cfg_a_ff[CLP_A_SEQ] && !reg_wr;
	assign seq_b = r.cfg_b_ff[CLP_B_SEQ] && !reg_wr;
	assign ff_a  = seq_a && !r.cfg_a_ff[CLP_A_LATCH];

	property p_lut_a;
		@(posedge ref_clk) disable iff (rst)
		(!r.cfg_a_ff[CLP_A_SEQ] && !reg_wr) |=>
			cell_a_out == $past(r.cfg_a_ff[32'(idx_a)]);
	endproperty
	a_lut_a: assert property (p_lut_a) else $error("table output wrong");

	property p_ff_rise;
		@(posedge ref_clk) disable iff (rst)
		(ff_a && !r.cfg_a_ff[CLP_A_CKINV] && a_in1 && !r.clk_prev_ff[0]) |=>
			r.q_a_ff == $past(a_in0);
	endproperty
	a_ff_rise: assert property (p_ff_rise) else $error("rise load missed");

	property p_ff_fall;
		@(posedge ref_clk) disable iff (rst)
		(ff_a && r.cfg_a_ff[CLP_A_CKINV] && !a_in1 && r.clk_prev_ff[0]) |=>
			r.q_a_ff == $past(a_in0);
	endproperty
	a_ff_fall: assert property (p_ff_fall) else $error("fall load missed");

	property p_ff_hold;
		@(posedge ref_clk) disable iff (rst)
		(ff_a && a_in1 == r.clk_prev_ff[0]) |=> $stable(r.q_a_ff);
	endproperty
	a_ff_hold: assert property (p_ff_hold) else $error("flop changed without edge");

	property p_latch_hold;
		@(posedge ref_clk) disable iff (rst)
		(seq_a && r.cfg_a_ff[CLP_A_LATCH] && (a_in1 ^ r.cfg_a_ff[CLP_A_CKINV])) |=>
			$stable(r.q_a_ff);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch not holding");

	property p_latch_pass;
		@(posedge ref_clk) disable iff (rst)
		(seq_a && r.cfg_a_ff[CLP_A_LATCH] && r.cfg_a_ff[CLP_A_CKINV] && a_in1) |=>
			r.q_a_ff == $past(a_in0);
	endproperty
	a_latch_pass: assert property (p_latch_pass) else $error("latch not passing");

	property p_outpol;
		@(posedge ref_clk) disable iff (rst)
		seq_a |=> cell_a_out == (r.q_a_ff ^ $past(r.cfg_a_ff[CLP_A_QINV]));
	endproperty
	a_outpol: assert property (p_outpol) else $error("output polarity wrong");

	property p_init;
		@(posedge ref_clk) disable iff (rst)
		(reg_wr && reg_addr == CLP_ADDR_CFG_A) |=>
			r.q_a_ff == $past(reg_wdata[CLP_A_INIT]);
	endproperty
	a_init: assert property (p_init) else $error("initial state not loaded");

	property p_clr_pre;
		@(posedge ref_clk) disable iff (rst)
		(!reg_wr && !b_in2) |=> r.q_b_ff == $past(r.cfg_b_ff[CLP_B_PRESET]);
	endproperty
	a_clr_pre: assert property (p_clr_pre) else $error("clear or preset failed");

	property p_pipe_clr;
		@(posedge ref_clk) disable iff (rst)
		(r.cfg_c_ff[CLP_C_PIPE] && !reg_wr && !c_in2) |=>
			(r.pipe_ff == 8'h00 && !pipe_tap_first && !pipe_tap_second);
	endproperty
	a_pipe_clr: assert property (p_pipe_clr) else $error("pipe clear failed");

	property p_pipe_shift;
		@(posedge ref_clk) disable iff (rst)
		(r.cfg_c_ff[CLP_C_PIPE] && !reg_wr && c_in2 && pipe_rise) |=>
			r.pipe_ff == {$past(r.pipe_ff[6:0]), $past(c_in0)};
	endproperty
	a_pipe_shift: assert property (p_pipe_shift) else $error("pipe did not shift");

	property p_pipe_tap;
		@(posedge ref_clk) disable iff (rst)
		(r.cfg_c_ff[CLP_C_PIPE] && !reg_wr && c_in2) |=>
			pipe_tap_first == r.pipe_ff[r.cfg_c_ff[CLP_C_TAP0 +: 3]];
	endproperty
	a_pipe_tap: assert property (p_pipe_tap) else $error("tap select wrong");

	property p_lut_b;
		@(posedge ref_clk) disable iff (rst)
		(!r.cfg_b_ff[CLP_B_SEQ] && !reg_wr) |=>
			cell_b_out == $past(r.cfg_b_ff[CLP_B_LUT + 32'(idx_b)]);
	endproperty
	a_lut_b: assert property (p_lut_b) else $error("set/reset cell table output wrong");

	property p_lut_c;
		@(posedge ref_clk) disable iff (rst)
		(!r.cfg_c_ff[CLP_C_PIPE] && !reg_wr) |=>
			(pipe_tap_first == $past(r.cfg_c_ff[CLP_C_LUT + 32'(idx_c)]) && !pipe_tap_second);
	endproperty
	a_lut_c: assert property (p_lut_c) else $error("pipe cell table output wrong");

	property p_latch_low;
		@(posedge ref_clk) disable iff (rst)
		(seq_a && r.cfg_a_ff[CLP_A_LATCH] && !r.cfg_a_ff[CLP_A_CKINV] && !a_in1) |=>
			r.q_a_ff == $past(a_in0);
	endproperty
	a_latch_low: assert property (p_latch_low) else $error("latch not passing on low");

	property p_ff_b_rise;
		@(posedge ref_clk) disable iff (rst)
		(seq_b && !r.cfg_b_ff[CLP_B_LATCH] && !r.cfg_b_ff[CLP_B_CKINV] && b_in2 && b_in1
			&& !r.clk_prev_ff[1]) |=> r.q_b_ff == $past(b_in0);
	endproperty
	a_ff_b_rise: assert property (p_ff_b_rise) else $error("set/reset flop load missed");

	property p_outpol_b;
		@(posedge ref_clk) disable iff (rst)
		seq_b |=>
			cell_b_out == (r.q_b_ff ^ $past(r.cfg_b_ff[CLP_B_QINV]));
	endproperty
	a_outpol_b: assert property (p_outpol_b) else $error("set/reset polarity wrong");

	property p_init_b;
		@(posedge ref_clk) disable iff (rst)
		(reg_wr && reg_addr == CLP_ADDR_CFG_B) |=>
			r.q_b_ff == $past(reg_wdata[CLP_B_INIT]);
	endproperty
	a_init_b: assert property (p_init_b) else $error("set/reset initial state wrong");

	property p_tap_second;
		@(posedge ref_clk) disable iff (rst)
		(r.cfg_c_ff[CLP_C_PIPE] && !reg_wr && c_in2) |=>
			pipe_tap_second ==
				(r.pipe_ff[r.cfg_c_ff[CLP_C_TAP1 +: 3]] ^ r.cfg_c_ff[CLP_C_QINV1]);
	endproperty
	a_tap_second: assert property (p_tap_second) else $error("second tap wrong");

	property p_pipe_hold;
		@(posedge ref_clk) disable iff (rst)
		(r.cfg_c_ff[CLP_C_PIPE] && !reg_wr && c_in2 && !pipe_rise) |=>
			$stable(r.pipe_ff);
	endproperty
	a_pipe_hold: assert property (p_pipe_hold) else $error("pipe moved without edge");

endmodule : clp_cells

`default_nettype wire

// ---- clp_pkg.sv ----
// Constants, register map and state layout for the configurable logic cells.
package clp_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CLP_ADDR_CFG_A  = 8'h00;
	localparam logic [7:0]  CLP_ADDR_CFG_B  = 8'h04;
	localparam logic [7:0]  CLP_ADDR_CFG_C  = 8'h08;
	localparam logic [7:0]  CLP_ADDR_STATUS = 8'h0c;
	localparam logic [31:0] CLP_CFG_RESET   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CLP_SEL_W    = 5;
	localparam int CLP_A_LUT    = 0;
	localparam int CLP_A_SEQ    = 4;
	localparam int CLP_A_LATCH  = 5;
	localparam int CLP_A_CKINV  = 6;
	localparam int CLP_A_QINV   = 7;
	localparam int CLP_A_INIT   = 8;
	localparam int CLP_A_SEL0   = 9;
	localparam int CLP_A_SEL1   = 14;
	localparam int CLP_B_LUT    = 0;
	localparam int CLP_B_SEQ    = 8;
	localparam int CLP_B_LATCH  = 9;
	localparam int CLP_B_CKINV  = 10;
	localparam int CLP_B_QINV   = 11;
	localparam int CLP_B_INIT   = 12;
	localparam int CLP_B_PRESET = 13;
	localparam int CLP_B_SEL0   = 14;
	localparam int CLP_B_SEL1   = 19;
	localparam int CLP_B_SEL2   = 24;
	localparam int CLP_C_LUT    = 0;
	localparam int CLP_C_PIPE   = 8;
	localparam int CLP_C_TAP0   = 9;
	localparam int CLP_C_TAP1   = 12;
	localparam int CLP_C_QINV1  = 15;
	localparam int CLP_C_SEL0   = 16;
	localparam int CLP_C_SEL1   = 21;
	localparam int CLP_C_SEL2   = 26;

	// ----------------------------------------------------------------
	// State of the block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] cfg_a_ff;
		logic [31:0] cfg_b_ff;
		logic [31:0] cfg_c_ff;
		logic [2:0]  clk_prev_ff;
		logic        q_a_ff;
		logic        q_b_ff;
		logic [7:0]  pipe_ff;
		logic        out_a_ff;
		logic        out_b_ff;
		logic        tap0_ff;
		logic        tap1_ff;
		logic [31:0] rdata_ff;
	} clp_state_s;

endpackage : clp_pkg

// ---- clp_route_model.sv ----
// Model of the routing lines: ground, supply, bench levels and a routed clock.
`timescale 1ns/10ps
`default_nettype none
module clp_route_model (
	// Clock and bench levels
	input  wire logic        ref_clk,
	input  wire logic [28:1] usr_lines,
	// Routing lines to the cells
	output logic      [31:0] route_lines
);
	logic clk_line = 1'b0;
	// Line 31 is the supply, so unused clears can select it; line 0 is ground.
	// Line 30 carries the routed clock inverted.
	assign route_lines = {1'b1, ~clk_line, clk_line, usr_lines, 1'b0};
	// Moves the routed clock and holds it long enough for the cells to see it.
	task automatic set_clk(input logic v);
		@(posedge ref_clk);
		clk_line <= v;
		repeat (4) @(posedge ref_clk);
	endtask : set_clk
endmodule : clp_route_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the configurable logic cells.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import clp_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] route_lines;
	logic [28:1] usr = '0;
	wire  [3:0]  cells;
	logic        chk_go = 1'b0;
	logic        rd_d = 1'b0;
	logic [34:0] ent;
	logic [34:0] q[$];
	logic [31:0] r;
	int          errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	localparam logic [4:0] DV = 5'b00111;
	localparam logic [4:0] CK = 5'b10010;
	localparam logic [4:0] EX[4] = '{5'b01110, 5'b00111, 5'b11100, 5'b01110};

	always #5 ref_clk = ~ref_clk;

	clp_cells dut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .route_lines(route_lines),
		.cell_a_out(cells[0]), .cell_b_out(cells[1]),
		.pipe_tap_first(cells[2]), .pipe_tap_second(cells[3])
	);
	clp_route_model rt (.ref_clk(ref_clk), .usr_lines(usr), .route_lines(route_lines));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		q.push_back({3'd4, exp});
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask : rd

	// Notes the expected level of one cell output and asks the watcher to look.
	task automatic chk(input logic [2:0] s, input logic e);
		q.push_back({s, 31'h0, e});
		@(posedge ref_clk);
		chk_go <= 1'b1;
		@(posedge ref_clk);
		chk_go <= 1'b0;
	endtask : chk

	always @(posedge ref_clk) begin
		rd_d <= reg_rd;
		cyc++;
		if (rd_d || chk_go) begin
			ent = q.pop_front();
			if (ent[34])
				check(reg_rdata, ent[31:0]);
			else
				check({31'h0, cells[ent[33:32]]}, ent[31:0]);
		end
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		r = $urandom(32'he7d6);
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++)
			rd(8'(4 * i), CLP_CFG_RESET);
		wr(8'h10, 32'hffff_ffff);
		wr(CLP_ADDR_STATUS, 32'hffff_ffff);
		rd(8'h10, 32'h0);
		rd(CLP_ADDR_STATUS, 32'h0);
		r = $urandom() & 32'h0007_ffff;
		wr(CLP_ADDR_CFG_A, r);
		rd(CLP_ADDR_CFG_A, r);
		$display("registers done");
		r = $urandom();
		wr(CLP_ADDR_CFG_A, (2 << CLP_A_SEL1) | (1 << CLP_A_SEL0) | r[3:0]);
		wr(CLP_ADDR_CFG_B, (3 << CLP_B_SEL2) | (2 << CLP_B_SEL1) | (1 << CLP_B_SEL0) | r[11:4]);
		wr(CLP_ADDR_CFG_C, (3 << CLP_C_SEL2) | (2 << CLP_C_SEL1) | (1 << CLP_C_SEL0) | r[19:12]);
		for (int i = 0; i < 8; i++) begin
			usr <= {24'($urandom()), 1'b0, 3'(i)};
			repeat (4) @(posedge ref_clk);
			chk(3'd0, r[i % 4]);
			chk(3'd1, r[4 + i]);
			chk(3'd2, r[12 + i]);
			chk(3'd3, 1'b0);
		end
		$display("tables done");
		for (int m = 0; m < 4; m++) begin
			r = $urandom();
			usr[1] <= 1'b0;
			rt.set_clk(1'b0);
			wr(CLP_ADDR_CFG_A, (29 << CLP_A_SEL1) | (1 << CLP_A_SEL0) | (r[0] << CLP_A_QINV)
				| (m << CLP_A_LATCH) | (1 << CLP_A_SEQ));
			wr(CLP_ADDR_CFG_B, (31 << CLP_B_SEL2) | (29 << CLP_B_SEL1) | (1 << CLP_B_SEL0)
				| (r[0] << CLP_B_QINV) | (m << CLP_B_LATCH) | (1 << CLP_B_SEQ));
			for (int s = 0; s < 5; s++) begin
				usr[1] <= DV[s];
				rt.set_clk(CK[s]);
				chk(3'd0, EX[m][s] ^ r[0]);
				chk(3'd1, EX[m][s] ^ r[0]);
			end
		end
		$display("flip-flops and latches done");
		for (int p = 0; p < 2; p++) begin
			usr[1] <= ~p[0];
			usr[4] <= 1'b0;
			rt.set_clk(1'b0);
			wr(CLP_ADDR_CFG_A, (29 << CLP_A_SEL1) | (1 << CLP_A_SEL0) | (1 << CLP_A_INIT)
				| (1 << CLP_A_SEQ));
			wr(CLP_ADDR_CFG_B, (4 << CLP_B_SEL2) | (29 << CLP_B_SEL1) | (1 << CLP_B_SEL0)
				| (p << CLP_B_PRESET) | ((1 - p) << CLP_B_INIT) | (1 << CLP_B_SEQ));
			repeat (2) @(posedge ref_clk);
			chk(3'd0, 1'b1);
			chk(3'd1, p[0]);
			rt.set_clk(1'b1);
			chk(3'd1, p[0]);
			usr[4] <= 1'b1;
			rt.set_clk(1'b0);
			rt.set_clk(1'b1);
			chk(3'd1, ~p[0]);
		end
		$display("clear and preset done");
		for (int n = 1; n <= 8; n++) begin
			usr[1] <= 1'b0;
			usr[4] <= 1'b1;
			rt.set_clk(1'b0);
			wr(CLP_ADDR_CFG_C, (4 << CLP_C_SEL2) | (29 << CLP_C_SEL1) | (1 << CLP_C_SEL0)
				| ((n % 2) << CLP_C_QINV1) | ((8 - n) << CLP_C_TAP1)
				| ((n - 1) << CLP_C_TAP0) | (1 << CLP_C_PIPE));
			usr[1] <= 1'b1;
			for (int k = 1; k <= 8; k++) begin
				rt.set_clk(1'b1);
				rt.set_clk(1'b0);
				chk(3'd2, k >= n);
				chk(3'd3, (k >= 9 - n) ^ n[0]);
			end
			usr[4] <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk(3'd2, 1'b0);
			chk(3'd3, 1'b0);
		end
		$display("pipe done");
		repeat (3) @(posedge ref_clk);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
